// ==== verilog/soft_serial_transceiver.sv ====
// Purpose: Serial transceiver, one transmit pin and one receive pin
// Assumes: 25 MHz clk_sys, 8N1 framing, no software registers
// Notes:   Each bit spans two half-bit delay units
`include "soft_serial_transceiver_map.svh"
`timescale 1ns/1ps
`default_nettype none

// One half-bit count times both directions; 9600 baud takes a quarter of the default count
module soft_serial_transceiver #(
  parameter logic [`SST_CNT_W-1:0] HALF_BIT_CYCLES = `SST_CNT_W'(`SST_HALF_BIT_CYCLES)
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       clkEn,
  input  wire logic       receivePin,
  output logic            transmitPin,
  input  wire logic       txValid,
  output logic            txReady,
  input  wire logic [7:0] txData,
  output logic            rxValid,
  output logic [7:0]      rxData
);

  // Two-stage synchroniser; only the second stage feeds logic
  // Both stages reset to the idle level so no false start bit follows reset
  logic rxMeta_q, rxSync_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rxMeta_q <= `SST_LINE_IDLE;
      rxSync_q <= `SST_LINE_IDLE;
    end else if (clkEn) begin
      rxMeta_q <= receivePin;
      rxSync_q <= rxMeta_q;
    end
  end

  // Shared by both directions so the two bit lengths cannot drift apart
  function automatic logic halfDone(input logic [`SST_CNT_W-1:0] cnt);
    halfDone = (cnt == HALF_BIT_CYCLES - `SST_CNT_W'(1));
  endfunction

  // Receiver: the counter runs in every busy state and is held at zero while idle,
  // so each frame is timed from the cycle in which the low level is seen
  soft_serial_transceiver_pkg::rx_state_t rxState_q, rxState_d;
  logic [`SST_CNT_W-1:0] rxCnt_q, rxCnt_d;
  logic                  rxHalf_q, rxHalf_d;
  logic [2:0]            rxBit_q, rxBit_d;
  logic [7:0]            rxShift_q, rxShift_d;
  logic [7:0]            rxData_d;
  logic                  rxValid_q, rxValid_d;

  always_comb begin
    rxState_d = rxState_q;
    rxCnt_d   = rxCnt_q + `SST_CNT_W'(1);
    rxHalf_d  = rxHalf_q;
    rxBit_d   = rxBit_q;
    rxShift_d = rxShift_q;
    rxData_d  = rxData;
    rxValid_d = 1'b0;
    if (halfDone(rxCnt_q)) begin
      rxCnt_d  = '0;
      rxHalf_d = ~rxHalf_q;
    end
    unique case (rxState_q)
      soft_serial_transceiver_pkg::RX_IDLE: begin
        rxCnt_d  = '0;
        rxHalf_d = 1'b0;
        // Level, not edge: a line still low after the stop mid-point restarts at once
        if (!rxSync_q) begin
          rxState_d = soft_serial_transceiver_pkg::RX_START;
        end
      end
      soft_serial_transceiver_pkg::RX_START: begin
        // One half bit puts the next sample points at mid-bit
        if (halfDone(rxCnt_q)) begin
          rxState_d = soft_serial_transceiver_pkg::RX_DATA;
          rxHalf_d  = 1'b0;
          rxBit_d   = '0;
        end
      end
      soft_serial_transceiver_pkg::RX_DATA: begin
        if (halfDone(rxCnt_q) && rxHalf_q) begin
          // Shifted in from the top so the first bit on the line lands in bit 0
          rxShift_d = {rxSync_q, rxShift_q[7:1]};
          rxBit_d   = rxBit_q + 3'(1);
          if (rxBit_q == 3'(`SST_DATA_BITS - 1)) begin
            rxState_d = soft_serial_transceiver_pkg::RX_STOP;
            rxData_d  = {rxSync_q, rxShift_q[7:1]};
            rxValid_d = 1'b1;
          end
        end
      end
      soft_serial_transceiver_pkg::RX_STOP: begin
        // Stop level ignored; wait to mid stop bit then rearm
        if (halfDone(rxCnt_q) && rxHalf_q) begin
          rxState_d = soft_serial_transceiver_pkg::RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rxState_q <= soft_serial_transceiver_pkg::RX_IDLE;
      rxCnt_q   <= '0;
      rxHalf_q  <= 1'b0;
      rxBit_q   <= '0;
      rxShift_q <= '0;
      rxData    <= '0;
      rxValid_q <= 1'b0;
    end else if (clkEn) begin
      rxState_q <= rxState_d;
      rxCnt_q   <= rxCnt_d;
      rxHalf_q  <= rxHalf_d;
      rxBit_q   <= rxBit_d;
      rxShift_q <= rxShift_d;
      rxData    <= rxData_d;
      rxValid_q <= rxValid_d;
    end
  end
  assign rxValid = rxValid_q;

  // Transmitter: a request is only taken while idle; txValid held during a frame
  // is ignored, so a busy caller never queues a second byte
  soft_serial_transceiver_pkg::tx_state_t txState_q, txState_d;
  logic [`SST_CNT_W-1:0] txCnt_q, txCnt_d;
  logic                  txHalf_q, txHalf_d;
  logic [2:0]            txBit_q, txBit_d;
  logic [7:0]            txShift_q, txShift_d;
  logic                  txLine_q, txLine_d;
  logic                  bitEnd;

  assign txReady = (txState_q == soft_serial_transceiver_pkg::TX_IDLE);
  assign bitEnd  = halfDone(txCnt_q) && txHalf_q;

  always_comb begin
    txState_d = txState_q;
    txCnt_d   = txCnt_q + `SST_CNT_W'(1);
    txHalf_d  = txHalf_q;
    txBit_d   = txBit_q;
    txShift_d = txShift_q;
    txLine_d  = txLine_q;
    if (halfDone(txCnt_q)) begin
      txCnt_d  = '0;
      txHalf_d = ~txHalf_q;
    end
    unique case (txState_q)
      soft_serial_transceiver_pkg::TX_IDLE: begin
        txCnt_d  = '0;
        txHalf_d = 1'b0;
        txLine_d = `SST_LINE_IDLE;
        if (txValid) begin
          txState_d = soft_serial_transceiver_pkg::TX_START;
          txShift_d = txData;
          txBit_d   = '0;
          txLine_d  = 1'b0;
        end
      end
      soft_serial_transceiver_pkg::TX_START: begin
        // Start bit done; the least significant bit goes out first
        if (bitEnd) begin
          txState_d = soft_serial_transceiver_pkg::TX_DATA;
          txLine_d  = txShift_q[0];
          txShift_d = txShift_q >> 1;
        end
      end
      soft_serial_transceiver_pkg::TX_DATA: begin
        if (bitEnd) begin
          txBit_d = txBit_q + 3'(1);
          // The stop bit follows the eighth data bit and lasts one whole bit
          if (txBit_q == 3'(`SST_DATA_BITS - 1)) begin
            txState_d = soft_serial_transceiver_pkg::TX_STOP;
            txLine_d  = 1'b1;
          end else begin
            txLine_d  = txShift_q[0];
            txShift_d = txShift_q >> 1;
          end
        end
      end
      soft_serial_transceiver_pkg::TX_STOP: begin
        if (bitEnd) begin
          txState_d = soft_serial_transceiver_pkg::TX_IDLE;
          txLine_d  = `SST_LINE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // Line register resets high so the pin idles before the first frame
      txState_q <= soft_serial_transceiver_pkg::TX_IDLE;
      txCnt_q   <= '0;
      txHalf_q  <= 1'b0;
      txBit_q   <= '0;
      txShift_q <= '0;
      txLine_q  <= `SST_LINE_IDLE;
    end else if (clkEn) begin
      txState_q <= txState_d;
      txCnt_q   <= txCnt_d;
      txHalf_q  <= txHalf_d;
      txBit_q   <= txBit_d;
      txShift_q <= txShift_d;
      txLine_q  <= txLine_d;
    end
  end
  assign transmitPin = txLine_q;

endmodule // soft_serial_transceiver

`default_nettype wire

// ==== include/soft_serial_transceiver_map.svh ====
// Purpose: Constants for the serial transceiver
// Assumes: 25 MHz system clock
// Notes:   Half-bit time is the base unit of all bit timing
`ifndef SOFT_SERIAL_TRANSCEIVER_MAP_SVH
`define SOFT_SERIAL_TRANSCEIVER_MAP_SVH

`define SST_CLK_HZ          25000000
`define SST_BAUD_DEFAULT    2400
`define SST_BAUD_FAST       9600
`define SST_HALF_BIT_CYCLES (`SST_CLK_HZ / (2 * `SST_BAUD_DEFAULT))
`define SST_DATA_BITS       8
`define SST_LINE_IDLE       1'b1
`define SST_CNT_W           16

`endif

// ==== include/soft_serial_transceiver_pkg.sv ====
// Purpose: Types for the serial transceiver
// Assumes: Nothing
// Notes:   States only; numbers live in the map header
package soft_serial_transceiver_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
endpackage

// ==== bench/soft_serial_transceiver_chk.sv ====
// Purpose: Port checker for the serial transceiver
// Assumes: clkEn high during frames, HALF_BIT_CYCLES of 4
// Notes:   A reset aborts all checks
`timescale 1ns/1ps
`default_nettype none
module soft_serial_transceiver_chk #(
  parameter logic [15:0] HALF_BIT_CYCLES = 16'h0004
) (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       clkEn,
  input wire logic       receivePin,
  input wire logic       transmitPin,
  input wire logic       txValid,
  input wire logic       txReady,
  input wire logic       rxValid,
  input wire logic [7:0] txData,
  input wire logic [7:0] rxData
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_idle_high: assert property (txReady |-> transmitPin) else $error("idle line low");
  chk_start_low: assert property (clkEn && txValid && txReady |=> !transmitPin && !txReady)
    else $error("no start");
  chk_frame_len: assert property ($fell(txReady) |-> ##79 !txReady ##1 txReady) else $error("frame length");
  chk_low_run: assert property ($fell(transmitPin) |-> !transmitPin[*8]) else $error("short low bit");
  chk_high_run: assert property ($rose(transmitPin) |-> transmitPin[*8]) else $error("short high bit");
  chk_stop_high: assert property ($rose(txReady) |-> $past(transmitPin, 8)) else $error("stop not high");
  chk_rx_pulse: assert property (rxValid |=> !rxValid) else $error("long valid");
  chk_rx_hold: assert property (!rxValid |-> $stable(rxData)) else $error("data moved");
  cover property (rxValid);
  cover property ($rose(txReady));
  cover property (rxValid && rxData == 8'hff);
  cover property (!clkEn && txValid && txReady);
endmodule // soft_serial_transceiver_chk
`default_nettype wire

// ==== bench/serial_host_model.sv ====
// Purpose: Host serial port at the far end of the link
// Assumes: BIT clock cycles per bit
// Notes:   Drives the line idle high between frames
`timescale 1ns/1ps
`default_nettype none
module serial_host_model #(
  parameter int BIT = 8
) (
  input  wire logic clk_sys,
  input  wire logic transmitPin,
  output logic      receivePin
);
  logic [7:0] got[$];
  initial receivePin = 1'b1;
  task automatic send(input logic [7:0] b, input logic stopLvl);
    logic [9:0] f;
    f = {stopLvl, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      receivePin = f[i];
      repeat (BIT) @(negedge clk_sys);
    end
    receivePin = 1'b1;
  endtask
  initial forever begin : decode
    logic [7:0] b;
    @(negedge transmitPin);
    repeat (BIT / 2) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge clk_sys);
      b[i] = transmitPin;
    end
    got.push_back(b);
  end
endmodule // serial_host_model
`default_nettype wire

// ==== bench/test_soft_serial_transceiver.sv ====
// Purpose: Self-checking bench for the serial transceiver
// Assumes: HALF_BIT_CYCLES of 4, so one bit is 8 clocks
// Notes:   clkEn drops only while both directions are idle, so frame counts stay fixed
`timescale 1ns/1ps
`default_nettype none
module test_soft_serial_transceiver;
  logic       clk_sys = 1'b0, sys_rst = 1'b1, txValid = 1'b0, transmitPin, txReady, rxValid, receivePin;
  logic       clkEn = 1'b1;
  logic [7:0] txData = 8'h00, rxData;
  int         mismatches = 0, n_tests = 0;
  initial forever #20 clk_sys = ~clk_sys;
  soft_serial_transceiver #(.HALF_BIT_CYCLES(16'h0004)) u_soft_serial_transceiver (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .clkEn(clkEn), .receivePin(receivePin), .transmitPin(transmitPin), .txValid(txValid),
    .txReady(txReady), .txData(txData), .rxValid(rxValid), .rxData(rxData));
  serial_host_model u_serial_host_model (.clk_sys(clk_sys), .transmitPin(transmitPin), .receivePin(receivePin));
  task automatic check(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic duplex(input logic [7:0] a, b, input logic stopLvl);
    int n;
    fork
      u_serial_host_model.send(b, stopLvl);
      begin
        txData = a;
        txValid = 1'b1;
        @(negedge clk_sys);
        txData = ~a; // Request held while busy must not start a frame
        repeat (40) @(negedge clk_sys);
        txValid = 1'b0;
      end
      begin
        n = 0;
        while (rxValid !== 1'b1 && n < 200) begin
          @(negedge clk_sys);
          n++;
        end
        check(rxData, b);
        check({7'h00, rxValid}, 8'h01);
      end
    join
    repeat (60) @(negedge clk_sys);
    check(8'(u_serial_host_model.got.size()), 8'h01);
    if (u_serial_host_model.got.size() > 0) check(u_serial_host_model.got.pop_front(), a);
  endtask
  initial begin
    logic [7:0] a, b;
    void'($urandom(70));
    repeat (12) @(negedge clk_sys);
    check({transmitPin, txReady, rxValid, 5'h00}, 8'hc0);
    check(rxData, 8'h00);
    sys_rst = 1'b0;
    for (int t = 0; t < 8; t++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      if (t < 2) begin
        a = {8{t[0]}};
        b = ~a;
      end
      clkEn = 1'b0; // Frozen while idle: a request must not start a frame
      txData = ~a;
      txValid = 1'b1;
      repeat (4) @(negedge clk_sys);
      check({transmitPin, txReady, rxValid, 5'h00}, 8'hc0);
      clkEn = 1'b1;
      txValid = 1'b0;
      @(negedge clk_sys);
      duplex(a, b, t != 7);
      $display("test %0d done", t);
    end
    report_and_stop;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    report_and_stop;
  end
endmodule // test_soft_serial_transceiver
bind soft_serial_transceiver soft_serial_transceiver_chk #(.HALF_BIT_CYCLES(HALF_BIT_CYCLES)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .receivePin(receivePin), .transmitPin(transmitPin),
  .txValid(txValid), .txReady(txReady), .rxValid(rxValid), .txData(txData), .rxData(rxData));
`default_nettype wire
